/* design/lcdlm_blink_div.sv */
// Frame-count divider giving the shared blink phase.
// Assumes frame_tick is a one-cycle pulse once per frame.
`timescale 1ns/1ps
module lcdlm_blink_div
    import lcdlm_pkg::*;
#(
    parameter int FRAMES = LCDLM_BLINK_FRAMES
) (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic frame_tick,
    output logic      blink_phase
);
    logic [7:0] cnt_r;

    // Count frames, flip the phase each period
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r       <= 8'h00;
            blink_phase <= 1'b0;
        end else if (frame_tick) begin
            if (cnt_r == 8'(FRAMES - 1)) begin
                cnt_r       <= 8'h00;
                blink_phase <= ~blink_phase;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end
endmodule

/* design/lcdlm_core.sv */
// Layer composition control: graphic home/area, mode decode, attributes.
// Assumes command bytes arrive as one-cycle strobes from the host port
// logic, and that the scan engine supplies row/column and fetched bytes.
`timescale 1ns/1ps
// Functional notes
// - Hold a 16-bit graphic home pointer for the top-left byte.
// - Graphic fetch address is home plus row times area plus column.
// - Column count from two pins, line count from four pins.
// - Area sets shown columns and row pitch; column count bounds it.
// - Each graphic column is one byte shown as eight dots.
// - Decoded modes persist until the next mode command.
// - Mode-set low bits pick OR, XOR, AND or text attribute.
// - Mode-set bit 3 selects internal or external character source.
// - Internal mode: codes below 80 from ROM, others external.
// - Attribute mode hides graphics; graphic bytes become attributes.
// - Attribute N sits N bytes after graphic home; host loads them.
// - Low attribute nibble decodes normal, reverse, inhibit, blink forms.
// - Display-mode 1001: bits graphic, text, cursor, cursor blink.
// - Display-mode with zero low bits blanks the whole output.
// - Command 42 loads home low/high; 43 loads area then zero.
module lcdlm_core
    import lcdlm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        cmd_stb,
    input  wire logic        cmd_is_cmd,
    input  wire logic [7:0]  cmd_byte,
    input  wire logic        column_select_pin_a,
    input  wire logic        column_select_pin_b,
    input  wire logic        line_select_pin_s,
    input  wire logic        line_select_pin_0,
    input  wire logic        line_select_pin_1,
    input  wire logic        dual_scan_pin,
    input  wire logic        frame_tick,
    input  wire logic [5:0]  scan_row,
    input  wire logic [6:0]  scan_col,
    input  wire logic [7:0]  char_code,
    input  wire logic [7:0]  text_row_byte,
    input  wire logic [7:0]  gfx_byte,
    input  wire logic        cursor_here,
    input  wire logic        pix_stb,
    output logic [15:0] gfx_fetch_addr,
    output logic        col_visible,
    output logic [6:0]  hardware_column_count,
    output logic [5:0]  hardware_line_count,
    output logic        font_from_rom,
    output logic [15:0] graphic_home_value,
    output logic [7:0]  graphic_area_value,
    output logic [2:0]  combine_mode,
    output logic        attr_mode,
    output logic        cg_external,
    output logic        gfx_on,
    output logic        text_on,
    output logic        cursor_on,
    output logic        cursor_blink,
    output logic        display_blank,
    output logic [7:0]  pixel_byte
);
    lcdlm_state_type state_r;
    logic [7:0]      op1_r;
    logic            is_ghome_r;
    logic            blink_phase;
    logic [15:0]     addr_nxt;
    logic [7:0]      txt_eff;
    logic [7:0]      gfx_eff;
    logic [7:0]      mix;
    logic            inhibit;
    logic            reverse;
    logic            blink;

    // Attribute decode, used by the pixel path only
    function automatic logic [2:0] attr_dec(input logic [7:0] a);
        // Returns {blink, reverse, inhibit}; upper nibble ignored
        unique case (a[3:0])
            LCDLM_AT_NORM:  attr_dec = 3'b000;
            LCDLM_AT_REV:   attr_dec = 3'b010;
            LCDLM_AT_INH:   attr_dec = 3'b001;
            LCDLM_AT_BNORM: attr_dec = 3'b100;
            LCDLM_AT_BREV:  attr_dec = 3'b110;
            LCDLM_AT_BINH:  attr_dec = 3'b101;
            default:        attr_dec = 3'b000;
        endcase
    endfunction

    always_comb begin
        unique case ({column_select_pin_b, column_select_pin_a})
            2'b11:   hardware_column_count = 7'd32;
            2'b10:   hardware_column_count = 7'd40;
            2'b01:   hardware_column_count = 7'd64;
            default: hardware_column_count = 7'd80;
        endcase
        // Lines: 4..32 in steps of 4 single scan, 2..16 in steps of 2 when dual scan
        hardware_line_count = dual_scan_pin
            ? {2'b00, line_select_pin_s, ~line_select_pin_1,
               ~line_select_pin_0, 1'b0} + 6'd2
            : {1'b0, line_select_pin_s, ~line_select_pin_1,
               ~line_select_pin_0, 2'b00} + 6'd4;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r    <= LCDLM_IDLE;
            op1_r      <= 8'h00;
            is_ghome_r <= 1'b0;
        end else if (cmd_stb) begin
            unique case (state_r)
                LCDLM_IDLE: begin
                    if (cmd_is_cmd && (cmd_byte == LCDLM_CMD_GHOME ||
                                       cmd_byte == LCDLM_CMD_GAREA)) begin
                        state_r    <= LCDLM_OP1;
                        is_ghome_r <= (cmd_byte == LCDLM_CMD_GHOME);
                    end
                end
                LCDLM_OP1: begin
                    op1_r   <= cmd_byte;
                    state_r <= LCDLM_OP2;
                end
                LCDLM_OP2: state_r <= LCDLM_IDLE;
            endcase
        end
    end

    // home pointer and area loaded on second operand
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            graphic_home_value <= LCDLM_GHOME_RST;
            graphic_area_value <= LCDLM_GAREA_RST;
        end else if (cmd_stb && state_r == LCDLM_OP2) begin
            if (is_ghome_r)
                graphic_home_value <= {cmd_byte, op1_r};
            else
                graphic_area_value <= op1_r;
        end
    end

    // mode-set decode held until next mode-set
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            combine_mode <= LCDLM_MSET_RST[2:0];
            cg_external  <= LCDLM_MSET_RST[3];
        end else if (cmd_stb && cmd_is_cmd && state_r == LCDLM_IDLE &&
                     cmd_byte[7:4] == LCDLM_NIB_MODESET) begin
            combine_mode <= cmd_byte[2:0];
            cg_external  <= cmd_byte[LCDLM_MS_CGEXT_BIT];
        end
    end
    assign attr_mode = (combine_mode == LCDLM_CMB_ATTR);

    // display-mode flags held until next display-mode
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {gfx_on, text_on, cursor_on, cursor_blink} <= LCDLM_DMODE_RST;
        end else if (cmd_stb && cmd_is_cmd && state_r == LCDLM_IDLE &&
                     cmd_byte[7:4] == LCDLM_NIB_DISPMODE) begin
            gfx_on       <= cmd_byte[LCDLM_DM_GFX_BIT];
            text_on      <= cmd_byte[LCDLM_DM_TXT_BIT];
            cursor_on    <= cmd_byte[LCDLM_DM_CUR_BIT];
            cursor_blink <= cmd_byte[LCDLM_DM_BLK_BIT];
        end
    end
    assign display_blank = ~(gfx_on | text_on | cursor_on | cursor_blink);

    // fetch address; area gives row pitch; same in attr
    always_comb begin
        addr_nxt = graphic_home_value
                 + 16'(scan_row) * 16'(graphic_area_value)
                 + {9'h000, scan_col};
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gfx_fetch_addr <= 16'h0000;
            col_visible    <= 1'b0;
        end else begin
            gfx_fetch_addr <= addr_nxt;
            // shown columns bounded by hardware count
            col_visible <= ({1'b0, scan_col} < graphic_area_value)
                        && (scan_col < hardware_column_count);
        end
    end

    // internal mode sends high codes to external font memory
    assign font_from_rom = ~cg_external & ~char_code[7];

    lcdlm_blink_div #(
        .FRAMES (LCDLM_BLINK_FRAMES)
    ) u_blink (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .frame_tick  (frame_tick),
        .blink_phase (blink_phase)
    );

    always_comb begin
        {blink, reverse, inhibit} = attr_mode ? attr_dec(gfx_byte) : 3'b000;
    end

    // bitwise combine of text and graphic bytes
    always_comb begin
        txt_eff = text_on ? text_row_byte : 8'h00;
        gfx_eff = (gfx_on && !attr_mode) ? gfx_byte : 8'h00;
        unique case (combine_mode)
            LCDLM_CMB_XOR: mix = txt_eff ^ gfx_eff;
            LCDLM_CMB_AND: mix = txt_eff & gfx_eff;
            default:       mix = txt_eff | gfx_eff;
        endcase
        if (attr_mode) begin
            // No text layer means nothing to show, reversed or not
            mix = (inhibit || !text_on) ? 8'h00 : (reverse ? ~txt_eff : txt_eff);
            if (blink && blink_phase)
                mix = 8'h00;
        end
        if (cursor_here && cursor_on && !(cursor_blink && blink_phase))
            mix = 8'hFF;
        if (display_blank)
            mix = 8'h00;
    end

    // one byte out as eight dots
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            pixel_byte <= 8'h00;
        else if (pix_stb)
            pixel_byte <= mix;
    end

    // Assertions
    property p_home_load;
        @(posedge mclk) disable iff (!rst_b)
        (cmd_stb && state_r == LCDLM_OP2 && is_ghome_r) |=>
            graphic_home_value == {$past(cmd_byte), $past(op1_r)};
    endproperty
    a_home_load: assert property (p_home_load)
        else $error("home pointer load wrong");
    property p_addr;
        @(posedge mclk) disable iff (!rst_b)
        1 |=> gfx_fetch_addr == $past(graphic_home_value)
              + 16'($past(scan_row)) * 16'($past(graphic_area_value))
              + {9'h000, $past(scan_col)};
    endproperty
    a_addr: assert property (p_addr)
        else $error("fetch address wrong");
    property p_cols;
        @(posedge mclk) disable iff (!rst_b)
        (column_select_pin_a && column_select_pin_b) |->
            hardware_column_count == 7'd32;
    endproperty
    a_cols: assert property (p_cols)
        else $error("column count wrong");
    property p_vis;
        @(posedge mclk) disable iff (!rst_b)
        ({1'b0, scan_col} >= graphic_area_value) |=> !col_visible;
    endproperty
    a_vis: assert property (p_vis)
        else $error("column past area visible");
    property p_persist;
        @(posedge mclk) disable iff (!rst_b)
        !(cmd_stb && cmd_is_cmd) |=> $stable(combine_mode) && $stable(gfx_on);
    endproperty
    a_persist: assert property (p_persist)
        else $error("mode changed without command");
    property p_modeset;
        @(posedge mclk) disable iff (!rst_b)
        (cmd_stb && cmd_is_cmd && state_r == LCDLM_IDLE &&
         cmd_byte == 8'h8C) |=> attr_mode && cg_external;
    endproperty
    a_modeset: assert property (p_modeset)
        else $error("mode-set decode wrong");
    property p_rom;
        @(posedge mclk) disable iff (!rst_b)
        char_code[7] |-> !font_from_rom;
    endproperty
    a_rom: assert property (p_rom)
        else $error("high code from rom");
    property p_attr_gfx;
        @(posedge mclk) disable iff (!rst_b)
        (pix_stb && attr_mode && !text_on && !cursor_here) |=>
            pixel_byte == 8'h00;
    endproperty
    a_attr_gfx: assert property (p_attr_gfx)
        else $error("graphic shown in attribute mode");
    property p_inh;
        @(posedge mclk) disable iff (!rst_b)
        (pix_stb && attr_mode && gfx_byte[3:0] == 4'h3 && !cursor_here)
            |=> pixel_byte == 8'h00;
    endproperty
    a_inh: assert property (p_inh)
        else $error("inhibit not applied");
    property p_blank;
        @(posedge mclk) disable iff (!rst_b)
        (pix_stb && display_blank) |=> pixel_byte == 8'h00;
    endproperty
    a_blank: assert property (p_blank)
        else $error("blank display drove pixels");
    property p_xor;
        @(posedge mclk) disable iff (!rst_b)
        (pix_stb && combine_mode == LCDLM_CMB_XOR && text_on && gfx_on &&
         !cursor_here) |=> pixel_byte == $past(text_row_byte ^ gfx_byte);
    endproperty
    a_xor: assert property (p_xor)
        else $error("xor combine wrong");
    c_home: cover property (@(posedge mclk) disable iff (!rst_b)
        cmd_stb && state_r == LCDLM_OP2 && is_ghome_r);
    c_attr: cover property (@(posedge mclk) disable iff (!rst_b)
        attr_mode && text_on && gfx_on && pix_stb);
    c_blink: cover property (@(posedge mclk) disable iff (!rst_b)
        $rose(blink_phase));
endmodule

/* design/lcdlm_pkg.sv */
// Package for the layer and mode control block of the LCD controller.
// Assumes a single 100 MHz clock domain and an 8-bit command byte stream.
package lcdlm_pkg;
    // Command codes and opcode fields
    localparam logic [7:0] LCDLM_CMD_GHOME    = 8'h42;
    localparam logic [7:0] LCDLM_CMD_GAREA    = 8'h43;
    localparam logic [3:0] LCDLM_NIB_MODESET  = 4'h8;
    localparam logic [3:0] LCDLM_NIB_DISPMODE = 4'h9;
    // Mode-set field positions
    localparam int LCDLM_MS_CGEXT_BIT = 3;
    // Display-mode field positions
    localparam int LCDLM_DM_GFX_BIT   = 3;
    localparam int LCDLM_DM_TXT_BIT   = 2;
    localparam int LCDLM_DM_CUR_BIT   = 1;
    localparam int LCDLM_DM_BLK_BIT   = 0;
    // Combine codes in the low three bits
    localparam logic [2:0] LCDLM_CMB_OR   = 3'h0;
    localparam logic [2:0] LCDLM_CMB_XOR  = 3'h1;
    localparam logic [2:0] LCDLM_CMB_AND  = 3'h3;
    localparam logic [2:0] LCDLM_CMB_ATTR = 3'h4;
    // Attribute low nibble codes
    localparam logic [3:0] LCDLM_AT_NORM   = 4'h0;
    localparam logic [3:0] LCDLM_AT_REV    = 4'h5;
    localparam logic [3:0] LCDLM_AT_INH    = 4'h3;
    localparam logic [3:0] LCDLM_AT_BNORM  = 4'h8;
    localparam logic [3:0] LCDLM_AT_BREV   = 4'hD;
    localparam logic [3:0] LCDLM_AT_BINH   = 4'hB;
    // Reset values
    localparam logic [15:0] LCDLM_GHOME_RST = 16'h0000;
    localparam logic [7:0]  LCDLM_GAREA_RST = 8'h00;
    localparam logic [3:0]  LCDLM_DMODE_RST = 4'h0;
    localparam logic [3:0]  LCDLM_MSET_RST  = 4'h0;
    // Frames per blink half period
    localparam int LCDLM_BLINK_FRAMES = 16;
    // Command sequencer states
    typedef enum logic [1:0] {
        LCDLM_IDLE, LCDLM_OP1, LCDLM_OP2
    } lcdlm_state_type;
endpackage

/* dv/lcdlm_host_model.sv */
// Host-side model sending command and operand bytes to the core.
// Assumes one clock; the host changes its bytes on falling edges only.
`timescale 1ns/1ps
module lcdlm_host_model
    import lcdlm_pkg::*;
(
    input  wire logic       mclk,
    output logic            cmd_stb,
    output logic            cmd_is_cmd,
    output logic [7:0]      cmd_byte
);
    // Bus quiet at time zero
    initial begin
        cmd_stb    = 1'b0;
        cmd_is_cmd = 1'b0;
        cmd_byte   = 8'h00;
    end
    // One byte per strobe; a released bus shows no stale value
    task automatic xfer(input logic k, input logic [7:0] b);
        @(negedge mclk);
        cmd_stb    = 1'b1;
        cmd_is_cmd = k;
        cmd_byte   = b;
        @(negedge mclk);
        cmd_stb    = 1'b0;
        cmd_is_cmd = ~k;
        cmd_byte   = ~b;
    endtask
    task automatic cmd3(input logic [7:0] op, d1, d2);
        xfer(1'b1, op);
        xfer(1'b0, d1);
        xfer(1'b0, d2);
    endtask
    task automatic both_layers(input logic [1:0] cur);
        xfer(1'b1, {LCDLM_NIB_DISPMODE, 2'b11, cur});
    endtask
endmodule

/* dv/tb_lcd_layer_mode_control.sv */
// Self-checking bench for the layer and mode control core.
// Assumes the host model drives command bytes on falling edges.
`timescale 1ns/1ps
module tb_lcd_layer_mode_control
    import lcdlm_pkg::*;
();
    logic        mclk, rst_b, cmd_stb, cmd_is_cmd, frame_tick;
    logic        column_select_pin_a, column_select_pin_b, dual_scan_pin;
    logic        line_select_pin_s, line_select_pin_0, line_select_pin_1;
    logic        cursor_here, pix_stb, col_visible, font_from_rom;
    logic        attr_mode, cg_external, gfx_on, text_on, cursor_on;
    logic        cursor_blink, display_blank, ext;
    logic [2:0]  combine_mode, m;
    logic [5:0]  scan_row, hardware_line_count;
    logic [6:0]  scan_col, hardware_column_count;
    logic [7:0]  cmd_byte, char_code, text_row_byte, gfx_byte, pixel_byte;
    logic [7:0]  graphic_area_value, area, t, g;
    logic [15:0] gfx_fetch_addr, graphic_home_value, home;
    logic [6:0]  cols_tab [4] = '{7'h50, 7'h40, 7'h28, 7'h20};
    logic [2:0]  cmb_tab [4] = '{LCDLM_CMB_OR, LCDLM_CMB_XOR,
                                 LCDLM_CMB_AND, LCDLM_CMB_ATTR};
    logic [3:0]  at_tab [6] = '{LCDLM_AT_NORM, LCDLM_AT_REV, LCDLM_AT_INH,
                                LCDLM_AT_BNORM, LCDLM_AT_BREV, LCDLM_AT_BINH};
    integer      seed = 32'h05b9_b755;
    int          bad_count = 0;
    int          tests_run = 0;
    int          tick_count = 0;

    // Free-running 100 MHz clock
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    // Random frame pulses feed the blink divider
    always @(negedge mclk) frame_tick <= ($random(seed) % 16) == 0;

    // Frame ticks seen out of reset, to model the blink phase
    always @(posedge mclk) begin
        if (rst_b && frame_tick)
            tick_count <= tick_count + 1;
    end

    lcdlm_host_model u_lcdlm_host_model (.mclk, .cmd_stb, .cmd_is_cmd,
        .cmd_byte);

    lcdlm_core u_lcdlm_core (.mclk, .rst_b, .cmd_stb, .cmd_is_cmd,
        .cmd_byte, .column_select_pin_a, .column_select_pin_b,
        .line_select_pin_s, .line_select_pin_0, .line_select_pin_1,
        .dual_scan_pin, .frame_tick, .scan_row, .scan_col, .char_code,
        .text_row_byte, .gfx_byte, .cursor_here, .pix_stb, .gfx_fetch_addr,
        .col_visible, .hardware_column_count, .hardware_line_count,
        .font_from_rom, .graphic_home_value, .graphic_area_value,
        .combine_mode, .attr_mode, .cg_external, .gfx_on, .text_on,
        .cursor_on, .cursor_blink, .display_blank, .pixel_byte);

    // Compare and count
    task automatic check(input logic [15:0] got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic finish_test;
        $display("tests %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Expected pixel byte for a combine code
    function automatic logic [7:0] exp_pix(input logic [2:0] c,
                                           input logic [7:0] tx, gx,
                                           input int ticks);
        case (c)
            LCDLM_CMB_XOR: return tx ^ gx;
            LCDLM_CMB_AND: return tx & gx;
            LCDLM_CMB_ATTR: begin
                // Inhibit wins, then the blink off phase, then reverse
                if (gx[3:0] == LCDLM_AT_INH || gx[3:0] == LCDLM_AT_BINH)
                    return 8'h00;
                if ((gx[3:0] == LCDLM_AT_BNORM || gx[3:0] == LCDLM_AT_BREV)
                    && (ticks / LCDLM_BLINK_FRAMES) % 2 == 1)
                    return 8'h00;
                if (gx[3:0] == LCDLM_AT_REV || gx[3:0] == LCDLM_AT_BREV)
                    return ~tx;
                return tx;
            end
            default: return tx | gx;
        endcase
    endfunction

    // Back-to-back pixel strobes with random bytes
    task automatic pix_round(input int n);
        logic [7:0] e;
        pix_stb = 1'b1;
        for (int i = 0; i < n; i++) begin
            t = 8'($random(seed));
            g = 8'($random(seed));
            if (m == LCDLM_CMB_ATTR) g[3:0] = at_tab[i % 6];
            text_row_byte = t;
            gfx_byte = g;
            // Phase before the capture edge decides the blink
            e = exp_pix(m, t, g, tick_count);
            @(negedge mclk);
            check(pixel_byte, e, "pixel");
        end
        pix_stb = 1'b0;
    endtask

    // Hang guard
    initial begin
        #200_000;
        bad_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test;
    end

    // Main sequence
    initial begin
        rst_b = 1'b0;
        {column_select_pin_a, column_select_pin_b, dual_scan_pin} = 3'h7;
        {line_select_pin_s, line_select_pin_0, line_select_pin_1} = 3'h3;
        {cursor_here, pix_stb, scan_row, scan_col} = 15'h0000;
        {char_code, text_row_byte, gfx_byte} = 24'h00_0000;
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        rst_b = 1'b1;
        check(graphic_home_value, LCDLM_GHOME_RST, "home rst");
        check(graphic_area_value, LCDLM_GAREA_RST, "area rst");
        check(display_blank, 1'b1, "blank rst");
        u_lcdlm_host_model.xfer(1'b0, 8'h55);
        check(graphic_area_value, LCDLM_GAREA_RST, "stray opd");
        check(hardware_line_count, 6'd2, "lines");
        line_select_pin_0 = 1'b0;
        text_row_byte = 8'hFF;
        gfx_byte = 8'hFF;
        {cursor_here, pix_stb} = 2'b11;
        @(negedge mclk);
        {cursor_here, pix_stb} = 2'b00;
        check(pixel_byte, 8'h00, "blank pix");
        check(hardware_line_count, 6'd4, "lines");
        $display("test reset done");
        for (int k = 0; k < 16; k++) begin
            u_lcdlm_host_model.xfer(1'b1, {LCDLM_NIB_DISPMODE, 4'(k)});
            check({gfx_on, text_on, cursor_on, cursor_blink}, 16'(k),
                  "dmode");
            check(display_blank, k == 0, "blank");
        end
        $display("test display mode done");
        for (int k = 0; k < 8; k++) begin
            m = cmb_tab[k % 4];
            ext = k[2];
            char_code = 8'($random(seed));
            u_lcdlm_host_model.both_layers(2'b00);
            u_lcdlm_host_model.xfer(1'b1, {LCDLM_NIB_MODESET, ext, m});
            check(combine_mode, m, "combine");
            check(attr_mode, m == LCDLM_CMB_ATTR, "attr");
            check(cg_external, ext, "cg src");
            check(font_from_rom, !ext && !char_code[7], "rom");
            // Long attribute rounds span both blink phases
            pix_round(m == LCDLM_CMB_ATTR ? 400 : 6);
        end
        u_lcdlm_host_model.xfer(1'b1, {LCDLM_NIB_DISPMODE, 4'h8});
        text_row_byte = 8'h5A;
        gfx_byte = {4'h0, LCDLM_AT_REV};
        pix_stb = 1'b1;
        @(negedge mclk);
        pix_stb = 1'b0;
        check(pixel_byte, 8'h00, "attr text off");
        u_lcdlm_host_model.xfer(1'b1, {LCDLM_NIB_DISPMODE, 4'hE});
        cursor_here = 1'b1;
        pix_stb = 1'b1;
        @(negedge mclk);
        {cursor_here, pix_stb} = 2'b00;
        check(pixel_byte, 8'hFF, "cursor");
        $display("test mode set done");
        for (int i = 0; i < 20; i++) begin
            home = 16'($random(seed));
            area = (i == 0) ? 8'h14 : 8'($random(seed));
            u_lcdlm_host_model.cmd3(LCDLM_CMD_GHOME, home[7:0], home[15:8]);
            u_lcdlm_host_model.cmd3(LCDLM_CMD_GAREA, area, 8'h00);
            check(graphic_home_value, home, "home");
            check(graphic_area_value, area, "area");
            for (int j = 0; j < 8; j++) begin
                {column_select_pin_b, column_select_pin_a} = 2'(j);
                scan_row = 6'($random(seed));
                scan_col = (j < 2) ? area[6:0] - 7'(j) : 7'($random(seed));
                @(negedge mclk);
                check(hardware_column_count, cols_tab[j % 4], "cols");
                check(gfx_fetch_addr, home + 16'(scan_row) * 16'(area)
                      + 16'(scan_col), "addr");
                check(col_visible, (8'(scan_col) < area) &&
                      (scan_col < cols_tab[j % 4]), "visible");
            end
        end
        check(combine_mode, m, "mode kept");
        check({gfx_on, text_on, cursor_on, cursor_blink}, 16'h000E,
              "dmode kept");
        $display("test address generation done");
        finish_test;
    end
endmodule
